// ==== core/fcw_fault_capture_watchdog.sv ====
`timescale 1ns/1ps
// How it works
// - Once the fault flag sets, the code register shows which source raised it.
// - Only the first reported error is captured; later ones ignored while held.
// - Software writes clear bit 1 then 0; then the next error is accepted.
// - Code bits 15..12 mean software, loop, stack and watchdog faults.
// - Bits 11..8 data mem1 banks, 7..4 data mem0, 3..2 program, 1..0 converters.
// - Code bits are read-only, reset to zero, one set for the captured source.
// - A software error stores the execute-stage program count.
// - Watchdog loads the start count and decrements once per tick.
// - Frame restart by the program reloads the watchdog to its start count.
// - Watchdog reaching zero raises a watchdog error to the fault logic.
// - Start count is a 13-bit field at bits 12..0, reset zero, rest reserved.
// - Total timeout is start count times the tick interval in clocks.
// - Select field bits 3..0: code 0 gives 64 clocks, doubling up to 131072.
// - Master fault flag is sticky until cleared by the clear control.
// - Each source has a mask bit; 1 blocks it, 0 lets it report.
module fcw_fault_capture_watchdog #(
   parameter int ADDR_W = 18
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic software_fault,
   input wire logic loop_fault,
   input wire logic stack_fault,
   input wire logic [3:0] data_mem1_fault,
   input wire logic [3:0] data_mem0_fault,
   input wire logic [1:0] program_mem_fault,
   input wire logic [1:0] rate_converter_fault,
   input wire logic [15:0] stage_program_count,
   input wire logic frame_restart,
   output logic fault_flag,
   output logic watchdog_error
);
   logic [15:0] error_source_code;
   logic [15:0] error_program_count;
   logic [15:0] source_mask;
   logic [12:0] timeout_start_field;
   logic [3:0] timeout_tick_select;
   logic fault_clear;
   logic [12:0] wd_count;
   logic wd_armed;
   logic [16:0] tick_count;
   logic tick;
   logic [16:0] tick_last;
   logic [3:0] select_eff;
   logic [15:0] raw_fault;
   logic [15:0] reported;
   logic [15:0] first_onehot;
   logic release_now;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [15:0] wr_idx;
   logic wr_hit;
   logic [15:0] rd_idx;
   logic [15:0] next_rdata;
   logic next_rhit;

   // Source vector in code layout
   always_comb begin
      raw_fault = 16'h0000;
      raw_fault[fcw_pkg::BIT_SOFTWARE] = software_fault;
      raw_fault[fcw_pkg::BIT_LOOP] = loop_fault;
      raw_fault[fcw_pkg::BIT_STACK] = stack_fault;
      raw_fault[fcw_pkg::BIT_WATCHDOG] = watchdog_error;
      raw_fault[fcw_pkg::BIT_DM1_LO +: 4] = data_mem1_fault;
      raw_fault[fcw_pkg::BIT_DM0_LO +: 4] = data_mem0_fault;
      raw_fault[fcw_pkg::BIT_PM_LO +: 2] = program_mem_fault;
      raw_fault[fcw_pkg::BIT_RC_LO +: 2] = rate_converter_fault;
   end

   assign reported = raw_fault & ~source_mask;

   // One bit only, highest source wins on a tie
   always_comb begin
      first_onehot = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (reported[i]) begin
            first_onehot = 16'h0001 << i;
         end
      end
   end

   // AXI write channel
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx = aw_addr[ADDR_W-1:2];
   assign wr_hit = (wr_idx == fcw_pkg::IDX_FAULT_CLEAR) || (wr_idx == fcw_pkg::IDX_FAULT_FLAG)
      || (wr_idx == fcw_pkg::IDX_ERROR_SOURCE_CODE) || (wr_idx == fcw_pkg::IDX_SOURCE_MASK)
      || (wr_idx == fcw_pkg::IDX_ERROR_PROGRAM_COUNT) || (wr_idx == fcw_pkg::IDX_TIMEOUT_START_VALUE)
      || (wr_idx == fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= fcw_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? fcw_pkg::RESP_OKAY : fcw_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable control registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fault_clear <= 1'b0;
         source_mask <= fcw_pkg::RST_MASK;
         timeout_start_field <= fcw_pkg::RST_START;
         timeout_tick_select <= fcw_pkg::RST_SELECT;
      end else if (do_write) begin
         if (wr_idx == fcw_pkg::IDX_FAULT_CLEAR) begin
            if (w_strb[0]) begin
               fault_clear <= w_data[0];
            end
         end else if (wr_idx == fcw_pkg::IDX_SOURCE_MASK) begin
            if (w_strb[0]) begin
               source_mask[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
               source_mask[15:8] <= w_data[15:8];
            end
         end else if (wr_idx == fcw_pkg::IDX_TIMEOUT_START_VALUE) begin
            if (w_strb[0]) begin
               timeout_start_field[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
               timeout_start_field[12:8] <= w_data[12:8];
            end
         end else if (wr_idx == fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER) begin
            if (w_strb[0]) begin
               timeout_tick_select <= w_data[3:0];
            end
         end
      end
   end

   // Release on the falling edge of the clear bit
   assign release_now = do_write && (wr_idx == fcw_pkg::IDX_FAULT_CLEAR) && w_strb[0]
      && fault_clear && !w_data[0];

   // Capture first error; a new error in the release cycle wins
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         error_source_code <= fcw_pkg::RST_CODE;
      end else if (error_source_code == 16'h0000 || release_now) begin
         error_source_code <= first_onehot;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fault_flag <= 1'b0;
      end else if (|reported) begin
         fault_flag <= 1'b1;
      end else if (release_now) begin
         fault_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         error_program_count <= fcw_pkg::RST_PC;
      end else if (software_fault) begin
         error_program_count <= stage_program_count;
      end else if (do_write && wr_idx == fcw_pkg::IDX_ERROR_PROGRAM_COUNT) begin
         if (w_strb[0]) begin
            error_program_count[7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            error_program_count[15:8] <= w_data[15:8];
         end
      end
   end

   // Tick divider
   assign select_eff = (timeout_tick_select > fcw_pkg::SELECT_MAX) ? fcw_pkg::SELECT_MAX
      : timeout_tick_select;
   // Largest code wraps to zero, so minus one still gives the full interval
   assign tick_last = (fcw_pkg::TICK_BASE << select_eff) - 17'h0_0001;
   assign tick = (tick_count == tick_last);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tick_count <= '0;
      end else if (frame_restart || tick || tick_count > tick_last) begin
         tick_count <= '0;
      end else begin
         tick_count <= tick_count + 17'h0_0001;
      end
   end

   // Down counter; total time is start count times interval
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wd_count <= '0;
         wd_armed <= 1'b0;
         watchdog_error <= 1'b0;
      end else begin
         watchdog_error <= 1'b0;
         if (frame_restart) begin
            wd_count <= timeout_start_field;
            wd_armed <= 1'b1;
         end else if (wd_armed && wd_count == 13'h0000) begin
            wd_armed <= 1'b0;
            watchdog_error <= 1'b1;
         end else if (wd_armed && tick) begin
            wd_count <= wd_count - 13'h0001;
         end
      end
   end

   // AXI read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_idx = s_axi_araddr[ADDR_W-1:2];

   always_comb begin
      next_rhit = 1'b1;
      next_rdata = 16'h0000;
      if (rd_idx == fcw_pkg::IDX_FAULT_CLEAR) begin
         next_rdata = {15'h0000, fault_clear};
      end else if (rd_idx == fcw_pkg::IDX_FAULT_FLAG) begin
         next_rdata = {15'h0000, fault_flag};
      end else if (rd_idx == fcw_pkg::IDX_ERROR_SOURCE_CODE) begin
         next_rdata = error_source_code;
      end else if (rd_idx == fcw_pkg::IDX_SOURCE_MASK) begin
         next_rdata = source_mask;
      end else if (rd_idx == fcw_pkg::IDX_ERROR_PROGRAM_COUNT) begin
         next_rdata = error_program_count;
      end else if (rd_idx == fcw_pkg::IDX_TIMEOUT_START_VALUE) begin
         next_rdata = {3'h0, timeout_start_field};
      end else if (rd_idx == fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER) begin
         next_rdata = {12'h000, timeout_tick_select};
      end else begin
         next_rhit = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= fcw_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, next_rdata};
         s_axi_rresp <= next_rhit ? fcw_pkg::RESP_OKAY : fcw_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ==== core/fcw_pkg.sv ====
package fcw_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_FAULT_CLEAR = 16'hf421;
   localparam logic [15:0] IDX_FAULT_FLAG = 16'hf427;
   localparam logic [15:0] IDX_ERROR_SOURCE_CODE = 16'hf428;
   localparam logic [15:0] IDX_SOURCE_MASK = 16'hf429;
   localparam logic [15:0] IDX_ERROR_PROGRAM_COUNT = 16'hf432;
   localparam logic [15:0] IDX_TIMEOUT_START_VALUE = 16'hf443;
   localparam logic [15:0] IDX_TIMEOUT_TICK_DIVIDER = 16'hf444;
   // Reset values
   localparam logic [15:0] RST_CODE = 16'h0000;
   localparam logic [15:0] RST_PC = 16'h0000;
   localparam logic [15:0] RST_MASK = 16'h0003;
   localparam logic [12:0] RST_START = 13'h0000;
   localparam logic [3:0] RST_SELECT = 4'h0;
   // Field layout
   localparam int START_W = 13;
   localparam int SELECT_W = 4;
   localparam int BIT_SOFTWARE = 15;
   localparam int BIT_LOOP = 14;
   localparam int BIT_STACK = 13;
   localparam int BIT_WATCHDOG = 12;
   localparam int BIT_DM1_LO = 8;
   localparam int BIT_DM0_LO = 4;
   localparam int BIT_PM_LO = 2;
   localparam int BIT_RC_LO = 0;
   // Tick interval timing: base 64 cycles, largest code 1011
   localparam int TICK_W = 17;
   localparam logic [16:0] TICK_BASE = 17'h0_0040;
   localparam logic [3:0] SELECT_MAX = 4'hb;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== testbench/fcw_monitor.sv ====
`timescale 1ns/1ps
module fcw_monitor (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic software_fault,
   input wire logic fault_flag,
   input wire logic watchdog_error
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_b_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_ar_held_off: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answering");
   a_aw_held_off: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while answering");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_soft_sets_flag: assert property (software_fault |=> fault_flag)
      else $error("software fault did not set flag");
   a_wd_sets_flag: assert property (watchdog_error |=> fault_flag)
      else $error("watchdog error did not set flag");
   a_wd_pulse: assert property (watchdog_error |=> !watchdog_error)
      else $error("watchdog error longer than one cycle");
   a_flag_sticky: assert property ($fell(fault_flag) && $past(rst_n) |-> $rose(s_axi_bvalid))
      else $error("flag fell without a register write");
endmodule
bind fcw_fault_capture_watchdog fcw_monitor i_fcw_monitor (.core_clk, .rst_n, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .software_fault, .fault_flag,
   .watchdog_error);

// ==== testbench/fcw_fault_capture_watchdog_tb_top.sv ====
`timescale 1ns/1ps
module fcw_fault_capture_watchdog_tb_top;
   localparam logic [1:0] OK = fcw_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = fcw_pkg::RESP_SLVERR;
   logic core_clk = 0;
   logic rst_n = 0;
   logic [17:0] s_axi_awaddr = 0;
   logic [17:0] s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic s_axi_awvalid = 0;
   logic s_axi_wvalid = 0;
   logic s_axi_arvalid = 0;
   logic [15:0] src = 0;
   logic [15:0] pc = 0;
   logic frame_restart = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault_flag, watchdog_error;
   logic [1:0] s_axi_bresp;
   logic [1:0] s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [1:0] q_b[$];
   logic [33:0] q_r[$];
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 32'h3cba;
   int n;
   initial forever #20 core_clk = ~core_clk;
   fcw_fault_capture_watchdog i_fcw_fault_capture_watchdog (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .software_fault(src[15]), .loop_fault(src[14]),
      .stack_fault(src[13]), .data_mem1_fault(src[11:8]), .data_mem0_fault(src[7:4]),
      .program_mem_fault(src[3:2]), .rate_converter_fault(src[1:0]), .stage_program_count(pc), .frame_restart,
      .fault_flag, .watchdog_error);
   task automatic wrap_up();
      $display("tests %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] r);
      logic ad;
      logic wd;
      ad = 0;
      wd = 0;
      q_b.push_back(r);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(ad && wd)) begin
         @(posedge core_clk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1;
            s_axi_awvalid <= 0;
         end
         if (!wd && s_axi_wready === 1'b1) begin
            wd = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic [1:0] r);
      q_r.push_back({r, 16'h0000, d});
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
   endtask
   task automatic clr();
      wr(fcw_pkg::IDX_FAULT_CLEAR, 16'h0001, OK);
      wr(fcw_pkg::IDX_FAULT_CLEAR, 16'h0000, OK);
   endtask
   task automatic wd_run(input logic [3:0] s, input logic [15:0] m);
      int lim;
      lim = m * (64 << s);
      wr(fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER, {12'h000, s}, OK);
      wr(fcw_pkg::IDX_TIMEOUT_START_VALUE, m, OK);
      frame_restart <= 1;
      @(posedge core_clk);
      frame_restart <= 0;
      repeat (50) @(posedge core_clk);
      frame_restart <= 1;
      @(posedge core_clk);
      frame_restart <= 0;
      n = 0;
      while (watchdog_error !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      n_tests++;
      if (n < lim - 8 || n > lim + 8) begin
         fail_count++;
         $display("ERROR %0t watchdog fired after %0d cycles", $time, n);
      end
      rd(fcw_pkg::IDX_ERROR_SOURCE_CODE, 16'h1000, OK);
      clr();
   endtask
   always @(posedge core_clk) begin
      if (s_axi_bvalid === 1'b1) begin
         n_tests++;
         if (q_b.size() == 0 || s_axi_bresp !== q_b.pop_front()) begin
            fail_count++;
            $display("ERROR %0t write response mismatch", $time);
         end
      end
      if (s_axi_rvalid === 1'b1) begin
         n_tests++;
         if (q_r.size() == 0 || {s_axi_rresp, s_axi_rdata} !== q_r.pop_front()) begin
            fail_count++;
            $display("ERROR %0t read mismatch data %h", $time, s_axi_rdata);
         end
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         $display("ERROR %0t timeout", $time);
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1;
      @(posedge core_clk);
      rd(fcw_pkg::IDX_ERROR_SOURCE_CODE, 16'h0000, OK);
      rd(fcw_pkg::IDX_ERROR_PROGRAM_COUNT, 16'h0000, OK);
      rd(fcw_pkg::IDX_TIMEOUT_START_VALUE, 16'h0000, OK);
      rd(fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER, 16'h0000, OK);
      rd(fcw_pkg::IDX_SOURCE_MASK, 16'h0003, OK);
      rd(fcw_pkg::IDX_FAULT_FLAG, 16'h0000, OK);
      rd(16'h0100, 16'h0000, ERR);
      wr(16'h0100, 16'h0001, ERR);
      wr(fcw_pkg::IDX_TIMEOUT_START_VALUE, 16'hffff, OK);
      rd(fcw_pkg::IDX_TIMEOUT_START_VALUE, 16'h1fff, OK);
      wr(fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER, 16'hffff, OK);
      rd(fcw_pkg::IDX_TIMEOUT_TICK_DIVIDER, 16'h000f, OK);
      wr(fcw_pkg::IDX_SOURCE_MASK, 16'h0000, OK);
      for (int i = 0; i < 16; i++) begin
         if (i != 12) begin
            pc <= 16'($random(seed));
            src <= 16'h0001 << i;
            @(posedge core_clk);
            src <= 16'h0001 << ((i + 5) % 12);
            @(posedge core_clk);
            src <= 0;
            n_tests++;
            if (fault_flag !== 1'b1) begin
               fail_count++;
               $display("ERROR %0t fault flag not set", $time);
            end
            rd(fcw_pkg::IDX_ERROR_SOURCE_CODE, 16'h0001 << i, OK);
            rd(fcw_pkg::IDX_FAULT_FLAG, 16'h0001, OK);
            clr();
            n_tests++;
            if (fault_flag !== 1'b0) begin
               fail_count++;
               $display("ERROR %0t fault flag not cleared", $time);
            end
            rd(fcw_pkg::IDX_ERROR_SOURCE_CODE, 16'h0000, OK);
            rd(fcw_pkg::IDX_FAULT_FLAG, 16'h0000, OK);
         end
      end
      rd(fcw_pkg::IDX_ERROR_PROGRAM_COUNT, pc, OK);
      wr(fcw_pkg::IDX_SOURCE_MASK, 16'h0001, OK);
      src <= 16'h0001;
      @(posedge core_clk);
      src <= 0;
      rd(fcw_pkg::IDX_FAULT_FLAG, 16'h0000, OK);
      rd(fcw_pkg::IDX_ERROR_SOURCE_CODE, 16'h0000, OK);
      wd_run(4'h0, 16'h0002);
      wd_run(4'h1, 16'h0003);
      wd_run(4'h2, 16'h0002);
      wrap_up();
   end
endmodule
